/* hw/ctrl_port_regs.vh */
// Purpose: Constants shared by the codec control port and its receive FIFO.
// Assumes: Included by its bare name from every design file that needs it.
// Notes: Definitions only; no logic lives here.
`ifndef CTRL_PORT_REGS_VH
`define CTRL_PORT_REGS_VH

// Seven-bit two-wire bus slave address.
`define DEV_ADDR 7'h18
// Byte width and FIFO depth on the data path.
`define BYTE_W 8
`define FIFO_DEPTH 16
`define FIFO_AW 4
// Bit counter values.
`define BIT_LAST 3'h7
`define BIT_ZERO 3'h0
// Two-wire bus states.
`define TW_IDLE 3'h0
`define TW_ADDR 3'h1
`define TW_AACK 3'h2
`define TW_WRX 3'h3
`define TW_WACK 3'h4
`define TW_RTX 3'h5
`define TW_RACK 3'h6
// Reset value for a byte register.
`define BYTE_ZERO 8'h00

`endif

/* hw/byte_fifo.v */
// Purpose: Flip-flop FIFO with valid and ready on both sides.
// Assumes: One clock, synchronous active-high reset.
// Notes: Full and empty are exact; a write and a read may share a cycle.
`timescale 1ns/10ps
`include "ctrl_port_regs.vh"

module byte_fifo #(
  parameter WIDTH = `BYTE_W,
  parameter DEPTH = `FIFO_DEPTH,
  parameter AW = `FIFO_AW
) (
  input wire mclk,
  input wire rst,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire do_wr;
  wire do_rd;

  // Handshakes and honest status flags.
  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr];
  assign do_wr = in_valid & in_ready;
  assign do_rd = out_valid & out_ready;

  // Storage is written at the write pointer.
  always @(posedge mclk) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and fill count.
  always @(posedge mclk) begin
    if (rst) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (do_wr & ~do_rd) begin
        count <= count + 1'b1;
      end else if (do_rd & ~do_wr) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule // byte_fifo

/* hw/codec_host_control_port.v */
// Purpose: Serial control port of the codec, four-wire or two-wire slave.
// Assumes: mclk at 40 MHz, far faster than the host serial clock.
// Notes: Received bytes go to a FIFO; reply bytes come from the user side.
`timescale 1ns/10ps
`include "ctrl_port_regs.vh"

// Contract
// - Strap high selects four-wire slave, strap low selects two-wire slave.
// - Shared clock, data, output and input pins follow the strap.
// - Four-wire mode uses select pin as slave select, clock idles low.
// - Full duplex: one byte out on master-in per byte in.
// - Two-wire mode answers only address 0011000.
// - Two-wire lines are only pulled low or released.
module codec_host_control_port (
  input wire mclk,
  input wire rst,
  input wire spi_select,
  input wire scl_ss_in,
  output reg scl_out,
  output reg scl_oe,
  input wire sclk_in,
  input wire sda_mosi_in,
  output reg sda_out,
  output reg sda_oe,
  output reg miso_out,
  output reg miso_oe,
  input wire general_purpose_input_pin,
  output reg general_purpose_output_pin,
  output reg [`BYTE_W-1:0] rx_data,
  output reg rx_valid,
  input wire rx_ready,
  input wire [`BYTE_W-1:0] tx_data,
  output reg tx_taken,
  output reg busy
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  reg [2:0] sel_s;
  reg [2:0] ss_s;
  reg [2:0] ck_s;
  reg [2:0] dt_s;
  reg [2:0] sck_s;
  reg sel;
  reg ss;
  reg ck;
  reg dt;
  reg sck;
  reg sck_prev;
  reg ck_prev;
  reg dt_prev;

  // Three stages per pin; a level counts once stages two and three agree.
  always @(posedge mclk) begin
    if (rst) begin
      sel_s <= 3'h0;
      ss_s <= 3'h7;
      ck_s <= 3'h7;
      dt_s <= 3'h7;
      sck_s <= 3'h0;
      sel <= 1'b0;
      ss <= 1'b1;
      ck <= 1'b1;
      dt <= 1'b1;
      sck <= 1'b0;
      sck_prev <= 1'b0;
      ck_prev <= 1'b1;
      dt_prev <= 1'b1;
    end else begin
      sel_s <= {sel_s[1:0], spi_select};
      ss_s <= {ss_s[1:0], scl_ss_in};
      ck_s <= {ck_s[1:0], scl_ss_in};
      dt_s <= {dt_s[1:0], sda_mosi_in};
      sck_s <= {sck_s[1:0], sclk_in};
      if (sel_s[1] == sel_s[2]) sel <= sel_s[2];
      if (ss_s[1] == ss_s[2]) ss <= ss_s[2];
      if (ck_s[1] == ck_s[2]) ck <= ck_s[2];
      if (dt_s[1] == dt_s[2]) dt <= dt_s[2];
      if (sck_s[1] == sck_s[2]) sck <= sck_s[2];
      sck_prev <= sck;
      ck_prev <= ck;
      dt_prev <= dt;
    end
  end

  // ****************************************************************
  // Receive FIFO
  // ****************************************************************
  reg [`BYTE_W-1:0] push_data;
  reg push;
  wire push_ready;
  wire [`BYTE_W-1:0] fifo_data;
  wire fifo_valid;
  wire pop;

  // The user side drains through the output register.
  assign pop = fifo_valid & (~rx_valid | rx_ready);

  byte_fifo #(.WIDTH(`BYTE_W), .DEPTH(`FIFO_DEPTH), .AW(`FIFO_AW)) u_fifo (
    .mclk(mclk),
    .rst(rst),
    .in_data(push_data),
    .in_valid(push),
    .in_ready(push_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(pop)
  );

  // Output register in front of the user.
  always @(posedge mclk) begin
    if (rst) begin
      rx_data <= `BYTE_ZERO;
      rx_valid <= 1'b0;
    end else if (pop) begin
      rx_data <= fifo_data;
      rx_valid <= 1'b1;
    end else if (rx_ready) begin
      rx_valid <= 1'b0;
    end
  end

  // ****************************************************************
  // Serial engine
  // ****************************************************************
  wire sck_rise = sck & ~sck_prev;
  wire sck_fall = ~sck & sck_prev;
  wire ck_rise = ck & ~ck_prev;
  wire ck_fall = ~ck & ck_prev;
  wire tw_start = ck & ck_prev & dt_prev & ~dt;
  wire tw_stop = ck & ck_prev & ~dt_prev & dt;
  reg [`BYTE_W-1:0] shift_in;
  reg [`BYTE_W-1:0] shift_out;
  reg [2:0] bit_cnt;
  reg [2:0] tw_state;
  reg sda_low;
  reg nack_byte;
  reg have_byte;

  // Both protocols share the shifters; the strap picks which one runs.
  always @(posedge mclk) begin
    if (rst) begin
      shift_in <= `BYTE_ZERO;
      shift_out <= `BYTE_ZERO;
      bit_cnt <= `BIT_ZERO;
      tw_state <= `TW_IDLE;
      sda_low <= 1'b0;
      nack_byte <= 1'b0;
      have_byte <= 1'b0;
      push <= 1'b0;
      push_data <= `BYTE_ZERO;
      tx_taken <= 1'b0;
      miso_out <= 1'b0;
    end else begin
      push <= 1'b0;
      tx_taken <= 1'b0;
      if (sel) begin
        tw_state <= `TW_IDLE;
        sda_low <= 1'b0;
        if (ss) begin
          bit_cnt <= `BIT_ZERO;
          shift_out <= {tx_data[`BYTE_W-2:0], 1'b0};
          miso_out <= tx_data[`BYTE_W-1];
        // sample on rising edge, CPOL 0
        end else if (sck_rise) begin
          shift_in <= {shift_in[`BYTE_W-2:0], dt};
          bit_cnt <= bit_cnt + 1'b1;
          if (bit_cnt == `BIT_LAST) begin
            push_data <= {shift_in[`BYTE_W-2:0], dt};
            push <= push_ready;
            tx_taken <= 1'b1;
          end
        end else if (sck_fall) begin
          if (bit_cnt == `BIT_ZERO) begin
            shift_out <= {tx_data[`BYTE_W-2:0], 1'b0};
            miso_out <= tx_data[`BYTE_W-1];
          end else begin
            shift_out <= {shift_out[`BYTE_W-2:0], 1'b0};
            miso_out <= shift_out[`BYTE_W-1];
          end
        end
      end else if (tw_start) begin
        tw_state <= `TW_ADDR;
        bit_cnt <= `BIT_ZERO;
        have_byte <= 1'b0;
        sda_low <= 1'b0;
      end else if (tw_stop) begin
        tw_state <= `TW_IDLE;
        sda_low <= 1'b0;
      end else begin
        case (tw_state)
          `TW_ADDR, `TW_WRX: begin
            if (ck_rise) begin
              shift_in <= {shift_in[`BYTE_W-2:0], dt};
              bit_cnt <= bit_cnt + 1'b1;
              if (bit_cnt == `BIT_LAST) have_byte <= 1'b1;
            end else if (ck_fall && have_byte) begin
              // Eight bits in: decide on acknowledge; the flag keeps a zero byte valid.
              have_byte <= 1'b0;
              if (tw_state == `TW_ADDR) begin
                if (shift_in[`BYTE_W-1:1] == `DEV_ADDR) begin
                  sda_low <= 1'b1;
                  tw_state <= `TW_AACK;
                  nack_byte <= shift_in[0];
                end else begin
                  tw_state <= `TW_IDLE;
                end
              end else begin
                push_data <= shift_in;
                push <= push_ready;
                sda_low <= push_ready;
                tw_state <= `TW_WACK;
              end
            end
          end
          `TW_AACK, `TW_WACK: begin
            if (ck_fall) begin
              shift_in <= `BYTE_ZERO;
              if (tw_state == `TW_AACK && nack_byte) begin
                shift_out <= {tx_data[`BYTE_W-2:0], 1'b0};
                sda_low <= ~tx_data[`BYTE_W-1];
                tx_taken <= 1'b1;
                tw_state <= `TW_RTX;
              end else begin
                sda_low <= 1'b0;
                tw_state <= `TW_WRX;
              end
            end
          end
          `TW_RTX: begin
            if (ck_rise) begin
              bit_cnt <= bit_cnt + 1'b1;
            end else if (ck_fall) begin
              if (bit_cnt == `BIT_ZERO) begin
                sda_low <= 1'b0;
                tw_state <= `TW_RACK;
              end else begin
                sda_low <= ~shift_out[`BYTE_W-1];
                shift_out <= {shift_out[`BYTE_W-2:0], 1'b0};
              end
            end
          end
          `TW_RACK: begin
            // A high bit from the master ends the read.
            if (ck_rise) begin
              nack_byte <= ~dt;
            end else if (ck_fall) begin
              if (nack_byte) begin
                shift_out <= {tx_data[`BYTE_W-2:0], 1'b0};
                sda_low <= ~tx_data[`BYTE_W-1];
                tx_taken <= 1'b1;
                tw_state <= `TW_RTX;
              end else begin
                tw_state <= `TW_IDLE;
              end
            end
          end
          default: begin
            tw_state <= `TW_IDLE;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Shared pin assignment
  // ****************************************************************
  // Pin roles follow the strap; two-wire drivers only pull low.
  always @(posedge mclk) begin
    if (rst) begin
      scl_out <= 1'b0;
      scl_oe <= 1'b0;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      miso_oe <= 1'b0;
      general_purpose_output_pin <= 1'b0;
      busy <= 1'b0;
    end else begin
      scl_oe <= 1'b0;
      sda_oe <= ~sel & sda_low;
      miso_oe <= sel & ~ss;
      general_purpose_output_pin <= sel ? general_purpose_input_pin : 1'b0;
      busy <= sel ? ~ss : (tw_state != `TW_IDLE);
    end
  end

endmodule // codec_host_control_port

/* sim/ctrl_port_monitor.sv */
// Purpose: Port-level assertions for the codec control port.
// Assumes: Sees only the ports of the top module.
// Notes: Settling windows of eight cycles cover the input synchronisers.
`timescale 1ns/10ps
module ctrl_port_monitor (
  input wire mclk,
  input wire rst,
  input wire spi_select,
  input wire scl_ss_in,
  input wire scl_out,
  input wire scl_oe,
  input wire sclk_in,
  input wire sda_mosi_in,
  input wire sda_out,
  input wire sda_oe,
  input wire miso_out,
  input wire miso_oe,
  input wire general_purpose_input_pin,
  input wire general_purpose_output_pin,
  input wire [7:0] rx_data,
  input wire rx_valid,
  input wire rx_ready,
  input wire [7:0] tx_data,
  input wire tx_taken,
  input wire busy
);
  // ****************************************
  // Assertions on the pins and the user side.
  // ****************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  a_scl_released:
    assert property (!scl_oe && !scl_out) else $error("clock pin driven");
  a_sda_low_only:
    assert property (!sda_out) else $error("data pin driven high");
  a_sda_quiet_spi:
    assert property (spi_select [*8] |-> !sda_oe) else $error("data pulled in four-wire");
  a_twowire_pins_off:
    assert property ((!spi_select) [*8] |-> !miso_oe && !general_purpose_output_pin)
      else $error("four-wire pins active in two-wire");
  a_select_drives:
    assert property ((spi_select && !scl_ss_in) [*8] |-> miso_oe && busy)
      else $error("selected but not driving");
  a_deselect_quiet:
    assert property ((spi_select && scl_ss_in) [*8] |-> !miso_oe && !busy)
      else $error("deselected but active");
  a_gpo_echo:
    assert property ((spi_select && $stable(general_purpose_input_pin)) [*8]
      |-> general_purpose_output_pin == general_purpose_input_pin) else $error("echo wrong");
  a_taken_pulse:
    assert property (tx_taken |=> !tx_taken) else $error("taken longer than one cycle");
  a_rx_hold:
    assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
      else $error("received byte not held");
endmodule // ctrl_port_monitor

bind codec_host_control_port ctrl_port_monitor mon (.mclk(mclk), .rst(rst),
  .spi_select(spi_select), .scl_ss_in(scl_ss_in), .scl_out(scl_out), .scl_oe(scl_oe),
  .sclk_in(sclk_in), .sda_mosi_in(sda_mosi_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .miso_out(miso_out), .miso_oe(miso_oe), .rx_data(rx_data), .rx_valid(rx_valid),
  .general_purpose_input_pin(general_purpose_input_pin), .rx_ready(rx_ready),
  .general_purpose_output_pin(general_purpose_output_pin), .tx_data(tx_data),
  .tx_taken(tx_taken), .busy(busy));

/* sim/host_master.sv */
// Purpose: Behavioural host master for both serial modes.
// Assumes: Tasks are entered at a falling edge of mclk.
// Notes: Four-wire clock half period is four mclk cycles, 200 ns per bit; two-wire bits take 250 ns.
`timescale 1ns/10ps
module host_master (
  input wire mclk,
  input wire miso,
  input wire sda_wire,
  output reg ss_n,
  output reg sclk,
  output reg mosi,
  output reg scl_low,
  output reg sda_low
);
  // serial clock idles low, open-drain lines released.
  initial {ss_n, sclk, mosi, scl_low, sda_low} = 5'h10;

  // Waits a number of falling edges.
  task hw(input integer n);
    repeat (n) @(negedge mclk);
  endtask

  // select level; a released data line shows a changed value.
  task spi_sel(input lvl);
    ss_n = lvl;
    if (lvl) mosi = ~mosi;
    hw(8);
  endtask

  // master paces n bits, MSB first, samples before the fall.
  task spi_bits(input [7:0] tx, input integer n, output [7:0] rx);
    integer i;
    rx = 8'h00;
    for (i = 7; i > 7 - n; i = i - 1) begin
      mosi = tx[i];
      hw(4);
      sclk = 1'b1;
      hw(4);
      rx[i] = miso;
      sclk = 1'b0;
    end
  endtask

  // start condition: data pulled while clock released.
  task i2c_start;
    sda_low = 1'b1;
    hw(4);
    scl_low = 1'b1;
    hw(4);
  endtask

  // eight bits then the acknowledge slot, lines only pulled or released.
  task i2c_byte(input [7:0] b, output ack);
    integer i;
    for (i = 8; i >= 0; i = i - 1) begin
      sda_low = (i > 0) ? ~b[i-1] : 1'b0;
      hw(4);
      scl_low = 1'b0;
      hw(4);
      ack = ~sda_wire;
      scl_low = 1'b1;
      hw(2);
    end
  endtask

  // reads a byte with data released, then answers not-acknowledge.
  task i2c_read(output [7:0] d);
    integer i;
    d = 8'h00;
    sda_low = 1'b0;
    for (i = 8; i >= 0; i = i - 1) begin
      hw(4);
      scl_low = 1'b0;
      hw(4);
      if (i > 0) d[i-1] = sda_wire;
      scl_low = 1'b1;
      hw(2);
    end
  endtask

  // stop condition: data released while clock released.
  task i2c_stop;
    sda_low = 1'b1;
    hw(4);
    scl_low = 1'b0;
    hw(4);
    sda_low = 1'b0;
    hw(8);
  endtask
endmodule // host_master

/* sim/codec_host_control_port_bench.sv */
// Purpose: Self-checking bench for the codec control port.
// Assumes: Inputs change on falling edges of mclk.
// Notes: Shared pins are muxed by the strap as on the board.
`timescale 1ns/10ps
`define CHECK(nm, ex, got) begin total_checks = total_checks + 1; \
  if ((got) !== (ex)) begin error_cnt = error_cnt + 1; \
  $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module codec_host_control_port_bench;
  reg mclk = 1'b0;
  reg rst = 1'b1;
  reg spi_select = 1'b1;
  reg gpi = 1'b0;
  reg rx_ready = 1'b0;
  reg [7:0] tx_data = 8'h3C;
  integer error_cnt = 0;
  integer total_checks = 0;
  integer k;
  integer taken_cnt = 0;
  reg [7:0] r;
  reg ack;
  wire scl_out, scl_oe, sda_out, sda_oe, miso_out, miso_oe, gpo;
  wire rx_valid, tx_taken, busy, ss_n, sclk, mosi, scl_low, sda_low;
  wire [7:0] rx_data;
  // Pull-ups on the open-drain lines; an undriven reply line changes level.
  wire scl_wire = ~(scl_low | scl_oe);
  wire sda_wire = ~(sda_low | sda_oe);
  wire miso = miso_oe ? miso_out : ~miso_out;

  // host master clock, run here at 25 ns.
  always #12.5 mclk = ~mclk;

  // Counts every reply byte that the design reports as consumed.
  always @(posedge mclk) begin
    if (tx_taken === 1'b1) taken_cnt <= taken_cnt + 1;
  end

  host_master host (.mclk(mclk), .miso(miso), .sda_wire(sda_wire), .ss_n(ss_n),
    .sclk(sclk), .mosi(mosi), .scl_low(scl_low), .sda_low(sda_low));

  codec_host_control_port uut (.mclk(mclk), .rst(rst), .spi_select(spi_select),
    .scl_ss_in(spi_select ? ss_n : scl_wire), .scl_out(scl_out), .scl_oe(scl_oe),
    .sclk_in(sclk), .sda_mosi_in(spi_select ? mosi : sda_wire), .sda_out(sda_out),
    .sda_oe(sda_oe), .miso_out(miso_out), .miso_oe(miso_oe), .rx_data(rx_data),
    .general_purpose_input_pin(gpi), .general_purpose_output_pin(gpo),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data),
    .tx_taken(tx_taken), .busy(busy));

  // Takes one received byte from the user side and compares it.
  task pop(input [7:0] ex);
    integer n;
    n = 0;
    while (rx_valid !== 1'b1 && n < 60) begin
      @(negedge mclk);
      n = n + 1;
    end
    `CHECK("rx_data", ex, rx_data)
    rx_ready = 1'b1;
    @(negedge mclk);
    rx_ready = 1'b0;
    host.hw(4);
  endtask

  // Two bytes back to back under one select, reply shifted out meanwhile.
  task t_duplex;
    gpi = 1'b1;
    host.spi_sel(1'b0);
    host.spi_bits(8'hA5, 8, r);
    `CHECK("reply 1", 8'h3C, r)
    tx_data = 8'h69;
    host.spi_bits(8'h5A, 8, r);
    `CHECK("reply 2", 8'h69, r)
    host.spi_sel(1'b1);
    `CHECK("busy", 1'b0, busy)
    `CHECK("gpo echo", 1'b1, gpo)
    pop(8'hA5);
    pop(8'h5A);
    $display("test duplex done");
  endtask

  // A partial byte is dropped when select rises.
  task t_partial;
    tx_data = 8'hC3;
    gpi = 1'b0;
    host.spi_sel(1'b0);
    host.spi_bits(8'hFF, 4, r);
    host.spi_sel(1'b1);
    `CHECK("gpo echo low", 1'b0, gpo)
    host.spi_sel(1'b0);
    host.spi_bits(8'h81, 8, r);
    `CHECK("reply partial", 8'hC3, r)
    host.spi_sel(1'b1);
    pop(8'h81);
    $display("test partial done");
  endtask

  // bulk byte loading: sixteen in the FIFO plus the output register, one dropped.
  task t_fifo;
    host.spi_sel(1'b0);
    for (k = 0; k < 18; k = k + 1) host.spi_bits(k[7:0], 8, r);
    host.spi_sel(1'b1);
    for (k = 0; k < 17; k = k + 1) pop(k[7:0]);
    `CHECK("empty", 1'b0, rx_valid)
    $display("test fifo done");
  endtask

  // Two-wire mode: own address acknowledged, another ignored.
  task t_twowire;
    spi_select = 1'b0;
    host.hw(12);
    `CHECK("gpo off", 1'b0, gpo)
    host.i2c_start;
    host.i2c_byte(8'h30, ack);
    `CHECK("own address ack", 1'b1, ack)
    `CHECK("miso off", 1'b0, miso_oe)
    host.i2c_byte(8'h96, ack);
    `CHECK("data ack", 1'b1, ack)
    host.i2c_stop;
    pop(8'h96);
    tx_data = 8'hA6;
    k = taken_cnt;
    host.i2c_start;
    host.i2c_byte(8'h31, ack);
    `CHECK("read address ack", 1'b1, ack)
    host.i2c_read(r);
    `CHECK("read byte", 8'hA6, r)
    host.i2c_stop;
    `CHECK("reply taken", 1, taken_cnt - k)
    host.i2c_start;
    host.i2c_byte(8'h32, ack);
    `CHECK("other address", 1'b0, ack)
    host.i2c_stop;
    $display("test twowire done");
  endtask

  // Prints the counts and the verdict, then ends the run.
  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Main sequence after five reset cycles.
  initial begin
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    host.hw(8);
    t_duplex;
    t_partial;
    t_fifo;
    t_twowire;
    give_verdict;
  end

  // Watchdog well beyond the expected few thousand cycles.
  initial begin
    #500000;
    error_cnt = error_cnt + 1;
    give_verdict;
  end
endmodule // codec_host_control_port_bench
